// >>> hdl/tcsp_codec.sv
// Codec end of the four-wire TDM serial port with power-down and cascade output.
// Assumes link pins arrive asynchronously; all timing from core_clk_in.
//
// Summary of operation
// - Delayed frame sync, same width, feeds next slave
// - Board pulls delayed sync low, stand-alone slave
// - Board pulls delayed sync high, master or last
// - Frame sync falling starts send and receive
// - Master generates and drives frame sync
// - Slave takes frame sync from outside
// - Output bits change on rising bit clock
// - Serial output released outside frames
// - Input bits sampled on falling bit clock
// - DSP drives input data synchronised to clocks
// - Select high means master, low slave
// - Power-down low disables port, stops clocks
// - Power-down keeps configuration, resumes without reprogramming
// - Power-down clears counters, state and enables, not the FIFO
// - Hardware reset restores default configuration
// - All timing derived from master clock
`timescale 1ns/1ns
module tcsp_codec
   import tcsp_pkg::*;
#(
   parameter int HALF_PERIOD = HALF_DIV
) (
   input  wire logic                   core_clk_in,
   input  wire logic                   resetn_in,
   tcsp_if.codec_mp                    link,
   input  wire logic [WORD_W-1:0]      tx_data_in,
   input  wire logic                   tx_valid_in,
   output logic                        tx_ready_out,
   output logic      [WORD_W-1:0]      rx_data_out,
   output logic                        rx_valid_out,
   input  wire logic                   cfg_wr_in,
   input  wire logic [FRAME_CNT_W-1:0] cfg_frame_bits_in,
   output logic      [FRAME_CNT_W-1:0] cfg_frame_bits_out,
   output logic                        frame_active_out,
   output logic                        powered_down_out
);
   logic [SYNC_W-1:0]      sync1_q;
   logic [SYNC_W-1:0]      sync2_q;
   logic                   bclk_prev_q;
   logic                   master;
   logic                   active;
   logic [DIV_W-1:0]       div_q;
   logic                   bclk_q;
   logic                   div_end;
   logic                   rise_p;
   logic                   fall_p;
   logic [FRAME_CNT_W-1:0] frame_bits_q;
   logic [FRAME_CNT_W-1:0] frame_cnt_q;
   logic [FRAME_CNT_W-1:0] frame_cnt_d;
   logic                   frm_q;
   logic                   frm_now;
   logic                   frm_smp_q;
   tcsp_state_e            state_q;
   logic [BIT_IDX_W-1:0]   bit_idx_q;
   logic [WORD_W-1:0]      tx_sr_q;
   logic [WORD_W-1:0]      rx_sr_q;
   logic [WORD_W-1:0]      rx_data_q;
   logic                   rx_valid_q;
   logic                   dout_q;
   logic                   dout_oe_q;
   logic                   dly_q;
   logic [WORD_W-1:0]      fifo_data;
   logic                   fifo_valid;
   logic                   start;

   // Two-flop synchronisers for every pin that arrives from outside
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sync1_q     <= '0;
         sync2_q     <= '0;
         bclk_prev_q <= 1'b0;
      end else begin
         sync1_q     <= {link.power_down_n, link.ms_sel, link.din, link.frame_sync, link.bclk};
         sync2_q     <= sync1_q;
         bclk_prev_q <= sync2_q[S_BCLK];
      end
   end

   assign master = sync2_q[S_MS];
   assign active = sync2_q[S_PDN];

   // Bit clock divided down from the core clock when master
   assign div_end = div_q == DIV_W'(HALF_PERIOD - 1);
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         div_q  <= '0;
         bclk_q <= 1'b0;
      end else if (!active || !master) begin
         div_q  <= '0;
         bclk_q <= 1'b0;
      end else if (div_end) begin
         div_q  <= '0;
         bclk_q <= ~bclk_q;
      end else begin
         div_q  <= div_q + 1'b1;
      end
   end

   // A slave sees the edges late by the synchroniser depth; half-period must cover it
   always_comb begin
      if (!active) begin
         rise_p = 1'b0;
         fall_p = 1'b0;
      end else if (master) begin
         rise_p = div_end & ~bclk_q;
         fall_p = div_end & bclk_q;
      end else begin
         rise_p = tcsp_rise(bclk_prev_q, sync2_q[S_BCLK]);
         fall_p = tcsp_rise(sync2_q[S_BCLK], bclk_prev_q);
      end
   end

   // Frame length survives power-down; only a hardware reset restores it
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         frame_bits_q <= FRAME_BITS_RST;
      end else if (cfg_wr_in) begin
         frame_bits_q <= cfg_frame_bits_in;
      end
   end

   assign frame_cnt_d = (frame_cnt_q == frame_bits_q - 1'b1) ? '0 : frame_cnt_q + 1'b1;

   // Master frame sync: one bit period high at the last slot of each frame
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         frame_cnt_q <= '0;
         frm_q       <= 1'b0;
      end else if (!active || !master) begin
         frame_cnt_q <= '0;
         frm_q       <= 1'b0;
      end else if (rise_p) begin
         frame_cnt_q <= frame_cnt_d;
         frm_q       <= frame_cnt_d == frame_bits_q - 1'b1;
      end
   end

   assign frm_now = master ? frm_q : sync2_q[S_FRM];

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         frm_smp_q <= 1'b0;
      end else if (!active) begin
         frm_smp_q <= 1'b0;
      end else if (fall_p) begin
         frm_smp_q <= frm_now;
      end
   end

   // The rise after a high frame sync sample is where frame sync falls
   assign start = rise_p & (state_q == TCSP_IDLE) & frm_smp_q;

   tcsp_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) i_tcsp_fifo (
      .core_clk_in   (core_clk_in),
      .resetn_in     (resetn_in),
      .in_data_in    (tx_data_in),
      .in_valid_in   (tx_valid_in),
      .in_ready_out  (tx_ready_out),
      .out_data_out  (fifo_data),
      .out_valid_out (fifo_valid),
      .out_ready_in  (start)
   );

   // Transmit side and frame sequencing, all on rising bit clock
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q   <= TCSP_IDLE;
         bit_idx_q <= '0;
         tx_sr_q   <= '0;
         dout_q    <= 1'b0;
         dout_oe_q <= 1'b0;
         dly_q     <= 1'b0;
      end else if (!active) begin
         state_q   <= TCSP_IDLE;
         bit_idx_q <= '0;
         dout_oe_q <= 1'b0;
         dly_q     <= 1'b0;
      end else if (rise_p) begin
         case (state_q)
            TCSP_IDLE: begin
               if (frm_smp_q) begin
                  // An empty FIFO sends a zero word rather than stall the frame
                  tx_sr_q   <= fifo_valid ? fifo_data : '0;
                  dout_q    <= fifo_valid ? fifo_data[WORD_W-1] : 1'b0;
                  dout_oe_q <= 1'b1;
                  bit_idx_q <= BIT_MSB;
                  state_q   <= TCSP_SHIFT;
               end
            end
            TCSP_SHIFT: begin
               if (bit_idx_q == BIT_LSB) begin
                  dout_oe_q <= 1'b0;
                  dly_q     <= 1'b1;
                  state_q   <= TCSP_DELAY;
               end else begin
                  dout_q    <= tx_sr_q[bit_idx_q - 1'b1];
                  bit_idx_q <= bit_idx_q - 1'b1;
               end
            end
            TCSP_DELAY: begin
               dly_q   <= 1'b0;
               state_q <= TCSP_IDLE;
            end
            default: begin
               state_q <= TCSP_IDLE;
            end
         endcase
      end
   end

   // Receive side on falling bit clock
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_sr_q    <= '0;
         rx_data_q  <= '0;
         rx_valid_q <= 1'b0;
      end else begin
         rx_valid_q <= 1'b0;
         if (active && fall_p && state_q == TCSP_SHIFT) begin
            rx_sr_q <= {rx_sr_q[WORD_W-2:0], sync2_q[S_DATA]};
            if (bit_idx_q == BIT_LSB) begin
               rx_data_q  <= {rx_sr_q[WORD_W-2:0], sync2_q[S_DATA]};
               rx_valid_q <= 1'b1;
            end
         end
      end
   end

   assign link.bclk_c_o  = bclk_q;
   assign link.bclk_c_oe = master & active;
   assign link.frm_c_o   = frm_q;
   assign link.frm_c_oe  = master & active;
   assign link.dout_o    = dout_q;
   assign link.dout_oe   = dout_oe_q;
   // Driven only during its pulse; the board pull sets the idle level
   assign link.dly_o     = dly_q;
   assign link.dly_oe    = dly_q;

   assign rx_data_out        = rx_data_q;
   assign rx_valid_out       = rx_valid_q;
   assign cfg_frame_bits_out = frame_bits_q;
   assign frame_active_out   = state_q == TCSP_SHIFT;
   assign powered_down_out   = ~active;
endmodule : tcsp_codec

// >>> hdl/tcsp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides on core_clk_in; DEPTH a power of two.
`timescale 1ns/1ns
module tcsp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk_in,
   input  wire logic             resetn_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   output logic      [WIDTH-1:0] out_data_out,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             push;
   logic             pop;

   assign in_ready_out  = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid_out = wr_q != rd_q;
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;
   assign out_data_out  = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge core_clk_in) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule : tcsp_fifo

// >>> hdl/tcsp_host.sv
// DSP end of the TDM codec serial port: one 16-bit slot per frame.
// Generates bit clock and frame sync when the codec strap says slave.
`timescale 1ns/1ns
module tcsp_host
   import tcsp_pkg::*;
#(
   parameter int                     HALF_PERIOD = HALF_DIV,
   parameter logic [FRAME_CNT_W-1:0] FRAME_BITS  = FRAME_BITS_RST
) (
   input  wire logic              core_clk_in,
   input  wire logic              resetn_in,
   tcsp_if.host_mp                link,
   input  wire logic [WORD_W-1:0] tx_data_in,
   input  wire logic              tx_valid_in,
   output logic                   tx_ready_out,
   output logic      [WORD_W-1:0] rx_data_out,
   output logic                   rx_valid_out
);
   logic [S_MS:0]          sync1_q;
   logic [S_MS:0]          sync2_q;
   logic                   bclk_prev_q;
   logic                   gen;
   logic [DIV_W-1:0]       div_q;
   logic                   bclk_q;
   logic                   div_end;
   logic                   rise_p;
   logic                   fall_p;
   logic [FRAME_CNT_W-1:0] frame_cnt_q;
   logic [FRAME_CNT_W-1:0] frame_cnt_d;
   logic                   frm_q;
   logic                   frm_smp_q;
   logic                   busy_q;
   logic [BIT_IDX_W-1:0]   bit_idx_q;
   logic [WORD_W-1:0]      hold_q;
   logic                   hold_full_q;
   logic [WORD_W-1:0]      tx_sr_q;
   logic                   din_q;
   logic [WORD_W-1:0]      rx_sr_q;
   logic [WORD_W-1:0]      rx_data_q;
   logic                   rx_valid_q;

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sync1_q     <= '0;
         sync2_q     <= '0;
         bclk_prev_q <= 1'b0;
      end else begin
         sync1_q     <= {link.ms_sel, link.dout, link.frame_sync, link.bclk};
         sync2_q     <= sync1_q;
         bclk_prev_q <= sync2_q[S_BCLK];
      end
   end

   assign gen     = ~sync2_q[S_MS];
   assign div_end = div_q == DIV_W'(HALF_PERIOD - 1);

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         div_q  <= '0;
         bclk_q <= 1'b0;
      end else if (!gen || div_end) begin
         div_q  <= '0;
         bclk_q <= gen & ~bclk_q;
      end else begin
         div_q  <= div_q + 1'b1;
      end
   end

   assign rise_p = gen ? (div_end & ~bclk_q) : tcsp_rise(bclk_prev_q, sync2_q[S_BCLK]);
   assign fall_p = gen ? (div_end & bclk_q) : tcsp_rise(sync2_q[S_BCLK], bclk_prev_q);

   assign frame_cnt_d = (frame_cnt_q == FRAME_BITS - 1'b1) ? '0 : frame_cnt_q + 1'b1;

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         frame_cnt_q <= '0;
         frm_q       <= 1'b0;
         frm_smp_q   <= 1'b0;
      end else begin
         if (!gen) begin
            frame_cnt_q <= '0;
            frm_q       <= 1'b0;
         end else if (rise_p) begin
            frame_cnt_q <= frame_cnt_d;
            frm_q       <= frame_cnt_d == FRAME_BITS - 1'b1;
         end
         if (fall_p) begin
            frm_smp_q <= gen ? frm_q : sync2_q[S_FRM];
         end
      end
   end

   assign tx_ready_out = ~hold_full_q;

   // Word to send is held until the next frame; a load in the same cycle wins
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         busy_q      <= 1'b0;
         bit_idx_q   <= '0;
         hold_q      <= '0;
         hold_full_q <= 1'b0;
         tx_sr_q     <= '0;
         din_q       <= 1'b0;
      end else begin
         if (rise_p) begin
            if (!busy_q && frm_smp_q) begin
               tx_sr_q   <= hold_full_q ? hold_q : '0;
               din_q     <= hold_full_q ? hold_q[WORD_W-1] : 1'b0;
               hold_full_q <= 1'b0;
               bit_idx_q <= BIT_MSB;
               busy_q    <= 1'b1;
            end else if (busy_q && bit_idx_q == BIT_LSB) begin
               busy_q    <= 1'b0;
            end else if (busy_q) begin
               din_q     <= tx_sr_q[bit_idx_q - 1'b1];
               bit_idx_q <= bit_idx_q - 1'b1;
            end
         end
         // Last assignment wins, so a word offered at a frame start is not lost
         if (tx_valid_in && !hold_full_q) begin
            hold_q      <= tx_data_in;
            hold_full_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_sr_q    <= '0;
         rx_data_q  <= '0;
         rx_valid_q <= 1'b0;
      end else begin
         rx_valid_q <= 1'b0;
         if (fall_p && busy_q) begin
            rx_sr_q <= {rx_sr_q[WORD_W-2:0], sync2_q[S_DATA]};
            if (bit_idx_q == BIT_LSB) begin
               rx_data_q  <= {rx_sr_q[WORD_W-2:0], sync2_q[S_DATA]};
               rx_valid_q <= 1'b1;
            end
         end
      end
   end

   assign link.bclk_h_o  = bclk_q;
   assign link.bclk_h_oe = gen;
   assign link.frm_h_o   = frm_q;
   assign link.frm_h_oe  = gen;
   assign link.din       = din_q;
   assign rx_data_out    = rx_data_q;
   assign rx_valid_out   = rx_valid_q;
endmodule : tcsp_host

// >>> hdl/tcsp_if.sv
// Serial link between the codec end and the DSP end.
// Straps (ms_sel, power_down_n, dly_pull_high) are set by the board model.
`timescale 1ns/1ns
interface tcsp_if;
   logic bclk_c_o;
   logic bclk_c_oe;
   logic bclk_h_o;
   logic bclk_h_oe;
   logic frm_c_o;
   logic frm_c_oe;
   logic frm_h_o;
   logic frm_h_oe;
   logic din;
   logic dout_o;
   logic dout_oe;
   logic dly_o;
   logic dly_oe;
   logic ms_sel;
   logic power_down_n;
   logic dly_pull_high;
   logic bclk;
   logic frame_sync;
   logic dout;
   logic frame_sync_delayed_out;

   // Wire levels; undriven lines settle on their pull level
   assign bclk       = bclk_c_oe ? bclk_c_o : (bclk_h_oe ? bclk_h_o : 1'b0);
   assign frame_sync = frm_c_oe ? frm_c_o : (frm_h_oe ? frm_h_o : 1'b0);
   assign dout       = dout_oe ? dout_o : 1'b1;
   assign frame_sync_delayed_out = dly_oe ? dly_o : dly_pull_high;

   modport codec_mp (
      input  bclk, frame_sync, din, ms_sel, power_down_n,
      output bclk_c_o, bclk_c_oe, frm_c_o, frm_c_oe, dout_o, dout_oe, dly_o, dly_oe
   );
   modport host_mp (
      input  bclk, frame_sync, dout, ms_sel,
      output bclk_h_o, bclk_h_oe, frm_h_o, frm_h_oe, din
   );
endinterface : tcsp_if

// >>> hdl/tcsp_pkg.sv
// Constants and types shared by both ends of the TDM codec serial port.
// Assumes one core clock at 10 MHz on both ends.
package tcsp_pkg;
   localparam int                     WORD_W         = 16;
   localparam int                     FRAME_CNT_W    = 8;
   localparam logic [FRAME_CNT_W-1:0] FRAME_BITS_RST = 8'h20;
   localparam int                     HALF_DIV       = 8;
   localparam int                     DIV_W          = 4;
   localparam int                     FIFO_DEPTH     = 8;
   localparam int                     BIT_IDX_W      = 4;
   localparam logic [BIT_IDX_W-1:0]   BIT_MSB        = 4'hF;
   localparam logic [BIT_IDX_W-1:0]   BIT_LSB        = 4'h0;
   localparam int                     SYNC_W         = 5;
   localparam int                     S_BCLK         = 0;
   localparam int                     S_FRM          = 1;
   localparam int                     S_DATA         = 2;
   localparam int                     S_MS           = 3;
   localparam int                     S_PDN          = 4;

   typedef enum logic [1:0] {TCSP_IDLE, TCSP_SHIFT, TCSP_DELAY} tcsp_state_e;

   function automatic logic tcsp_rise(input logic prev, input logic cur);
      return cur & ~prev;
   endfunction : tcsp_rise
endpackage : tcsp_pkg

// >>> tb/tcsp_assertions.sv
// Concurrent checks on the link between the codec end and the DSP end.
// Assumes one core clock; instantiated beside the link interface, no bind.
`timescale 1ns/1ns
module tcsp_assertions #(
   parameter int HALF_PERIOD = 8
) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic bclk,
   input wire logic frame_sync,
   input wire logic din,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic dly_oe,
   input wire logic bclk_c_oe,
   input wire logic frm_c_oe,
   input wire logic frm_h_oe,
   input wire logic ms_sel,
   input wire logic power_down_n
);
   logic [9:0] slot_q;
   logic [9:0] dly_q;
   logic       clean_q;

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!resetn_in);

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         slot_q <= 10'h000;
      end else begin
         slot_q <= dout_oe ? slot_q + 10'h001 : 10'h000;
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         dly_q <= 10'h000;
      end else begin
         dly_q <= dly_oe ? dly_q + 10'h001 : 10'h000;
      end
   end

   // Widths are only judged on frames that no power-down has cut short
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         clean_q <= 1'b0;
      end else if (!power_down_n) begin
         clean_q <= 1'b0;
      end else if ($rose(dout_oe)) begin
         clean_q <= 1'b1;
      end
   end

   a_pdn_port_off: assert property (!power_down_n [*6] |-> !dout_oe && !dly_oe && !bclk_c_oe && !frm_c_oe)
      else $error("link still driven in power-down");
   a_master_drives: assert property ((power_down_n && ms_sel) [*6] |-> bclk_c_oe && frm_c_oe && !frm_h_oe)
      else $error("master end not driving clocks");
   a_slave_quiet: assert property (!ms_sel [*6] |-> !bclk_c_oe && !frm_c_oe && frm_h_oe)
      else $error("slave end drives clocks");
   a_frame_start_out: assert property ($fell(frame_sync) && power_down_n && $past(power_down_n, 24) |-> ##[0:8] dout_oe)
      else $error("no output after frame sync fell");
   a_dout_on_rise: assert property (dout_oe && $past(dout_oe) && $changed(dout) |-> bclk)
      else $error("output bit changed with bit clock low");
   a_din_on_rise: assert property (dout_oe && $past(dout_oe) && $changed(din) |-> bclk)
      else $error("input bit changed near falling edge");
   a_slot_length: assert property ($fell(dout_oe) && clean_q |-> slot_q == 10'(32 * HALF_PERIOD))
      else $error("output slot length wrong");
   a_dly_width: assert property ($fell(dly_oe) && clean_q |-> dly_q == 10'(2 * HALF_PERIOD))
      else $error("delayed frame sync width wrong");

   c_dly_pulse: cover property ($fell(dly_oe));
   c_master_frame: cover property (ms_sel && $rose(dout_oe));
   c_slave_frame: cover property (!ms_sel && $rose(dout_oe));
   c_power_down: cover property (!power_down_n [*6]);
endmodule : tcsp_assertions

// >>> tb/tcsp_test.sv
// Self-checking bench: codec end and DSP end joined over the link interface.
// Assumes 10 MHz core clock; expected words are the words each side pushed.
`timescale 1ns/1ns
module tcsp_test
   import tcsp_pkg::*;
;
   logic                   core_clk_in;
   logic                   resetn_in;
   logic [WORD_W-1:0]      tx_data[2];
   logic                   tx_valid[2];
   logic                   tx_ready[2];
   logic [WORD_W-1:0]      rx_data[2];
   logic                   rx_valid[2];
   logic                   cfg_wr;
   logic [FRAME_CNT_W-1:0] cfg_bits_in;
   logic [FRAME_CNT_W-1:0] cfg_bits;
   logic                   frame_active;
   logic                   powered_down;
   logic                   full_seen = 1'b0;
   logic                   act_seen  = 1'b0;
   logic [31:0]            rng_q;
   logic [WORD_W-1:0]      exp_q[2][$];
   int                     bad_count;
   int                     check_count;

   tcsp_if link ();

   tcsp_codec #(.HALF_PERIOD(HALF_DIV)) i_tcsp_codec (
      .core_clk_in(core_clk_in), .resetn_in(resetn_in), .link(link),
      .tx_data_in(tx_data[0]), .tx_valid_in(tx_valid[0]), .tx_ready_out(tx_ready[0]),
      .rx_data_out(rx_data[0]), .rx_valid_out(rx_valid[0]), .cfg_wr_in(cfg_wr),
      .cfg_frame_bits_in(cfg_bits_in), .cfg_frame_bits_out(cfg_bits),
      .frame_active_out(frame_active), .powered_down_out(powered_down));

   tcsp_host #(.HALF_PERIOD(HALF_DIV)) i_tcsp_host (
      .core_clk_in(core_clk_in), .resetn_in(resetn_in), .link(link),
      .tx_data_in(tx_data[1]), .tx_valid_in(tx_valid[1]), .tx_ready_out(tx_ready[1]),
      .rx_data_out(rx_data[1]), .rx_valid_out(rx_valid[1]));

   tcsp_assertions #(.HALF_PERIOD(HALF_DIV)) i_tcsp_assertions (
      .core_clk_in(core_clk_in), .resetn_in(resetn_in), .bclk(link.bclk),
      .frame_sync(link.frame_sync), .din(link.din), .dout(link.dout),
      .dout_oe(link.dout_oe), .dly_oe(link.dly_oe), .bclk_c_oe(link.bclk_c_oe),
      .frm_c_oe(link.frm_c_oe), .frm_h_oe(link.frm_h_oe), .ms_sel(link.ms_sel),
      .power_down_n(link.power_down_n));

   always #50 core_clk_in = ~core_clk_in;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check_word

   task automatic check_bit(input string name, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %b seen %b", name, exp, got);
      end
   endtask : check_bit

   task automatic wrap_up();
      if (bad_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up

   task automatic give_up(input string name);
      bad_count++;
      $display("Error %s expected done seen timeout", name);
      wrap_up();
   endtask : give_up

   task automatic do_reset(input logic master);
      resetn_in <= 1'b0;
      link.ms_sel <= master;
      link.dly_pull_high <= master;
      exp_q[0].delete();
      exp_q[1].delete();
      repeat (8) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      check_word("frame_bits", {8'h00, FRAME_BITS_RST}, {8'h00, cfg_bits});
      check_bit("delayed_idle", master, link.frame_sync_delayed_out);
   endtask : do_reset

   // Words 0000 and FFFF are what empty and released slots carry, so never sent
   task automatic push(input int side, input int n);
      logic [WORD_W-1:0] w;
      int                t;
      for (int i = 0; i < n; i++) begin
         rng_q = xs(rng_q);
         w = rng_q[15:0];
         if (w == 16'h0000 || w == 16'hFFFF) begin
            w = 16'h5A5A;
         end
         tx_data[side] <= w;
         tx_valid[side] <= 1'b1;
         t = 0;
         @(negedge core_clk_in);
         while (tx_ready[side] !== 1'b1 && t < 5000) begin
            @(negedge core_clk_in);
            t++;
         end
         if (t == 5000) begin
            give_up("push");
         end
         @(posedge core_clk_in);
         exp_q[side].push_back(w);
      end
      tx_valid[side] <= 1'b0;
   endtask : push

   task automatic drain();
      int t;
      t = 0;
      while (exp_q[0].size() + exp_q[1].size() != 0 && t < 20000) begin
         @(posedge core_clk_in);
         t++;
      end
      if (t == 20000) begin
         give_up("drain");
      end
   endtask : drain

   // Idle slot words are skipped; every pushed word must come out in order
   always @(negedge core_clk_in) begin
      if (tx_ready[0] === 1'b0) begin
         full_seen <= 1'b1;
      end
      if (frame_active === 1'b1) begin
         act_seen <= 1'b1;
      end
      for (int k = 0; k < 2; k++) begin
         if (rx_valid[k] === 1'b1 && exp_q[1-k].size() != 0
             && rx_data[k] !== 16'h0000 && rx_data[k] !== 16'hFFFF) begin
            check_word("rx_word", exp_q[1-k].pop_front(), rx_data[k]);
         end
      end
   end

   initial begin
      core_clk_in = 1'b0;
      resetn_in = 1'b0;
      tx_data = '{16'h0000, 16'h0000};
      tx_valid = '{1'b0, 1'b0};
      cfg_wr = 1'b0;
      cfg_bits_in = 8'h00;
      link.ms_sel = 1'b0;
      link.power_down_n = 1'b1;
      link.dly_pull_high = 1'b0;
      rng_q = 32'h0000001F;
      bad_count = 0;
      check_count = 0;
      @(posedge core_clk_in);
      do_reset(1'b0);
      fork
         push(0, 12);
         push(1, 12);
      join
      check_bit("fifo_full", 1'b1, full_seen);
      drain();
      cfg_bits_in <= 8'h28;
      cfg_wr <= 1'b1;
      @(posedge core_clk_in);
      cfg_wr <= 1'b0;
      link.power_down_n <= 1'b0;
      repeat (20) @(posedge core_clk_in);
      check_bit("powered_down", 1'b1, powered_down);
      check_bit("dout_released", 1'b1, link.dout);
      check_bit("frame_active", 1'b0, frame_active);
      push(0, 3);
      repeat (1100) @(posedge core_clk_in);
      check_word("held_words", 16'h0003, 16'(exp_q[0].size()));
      check_word("frame_bits", 16'h0028, {8'h00, cfg_bits});
      link.power_down_n <= 1'b1;
      drain();
      do_reset(1'b1);
      fork
         push(0, 6);
         push(1, 6);
      join
      drain();
      check_bit("frame_active_seen", 1'b1, act_seen);
      wrap_up();
   end
endmodule : tcsp_test
